// ---- adcsp_core.v ----
// adcsp_core.v - serial peripheral port of a four-channel converter
// assumes: serial clock, select and data-in are pins, sampled twice on
// sys_clk_i; conversion sets come from the converter core on sys_clk_i.
// How it works
// - mode 1, clock idles low, peripheral only
// - shift out on rise, capture on fall
// - select high: ignore clock, output floats
// - select rise restarts the frame
// - ready low on new data or detection
// - source select picks lagging, any, leading
// - global chop ignores source select
// - first ready delayed past phase boundary
// - open-drain option floats deasserted ready
// - level form: low until data out
// - pulse form: short low pulse
// - unread pulse skips the next result
// - no ready while data shifts out
// - word length 16, 24 or 32
// - timeout resets port after 2^15 clocks
// - first output word answers previous command
// - response, four channels, then check word
// - multi-read appends registers to response
// - multi-write lengthens frame per register
// - reset length 24, 16-bit words msb-aligned
// - 16 truncates, 32 pads or sign-extends
// - no-op answer is status with ready flags
`timescale 1ns/1ps
`include "adcsp_defs.vh"
module adcsp_core #(
  parameter TIMEOUT_CYC = `ADCSP_TIMEOUT_CYC,
  parameter FIFO_DEPTH  = 8
) (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  // serial pins
  input  wire        sclk_i,
  input  wire        cs_n_i,
  input  wire        din_i,
  output wire        dout_o,
  output wire        dout_oe_o,
  // ready pin (open-drain capable)
  output wire        data_ready_n_o,
  output wire        data_ready_n_oe_o,
  // configuration
  input  wire [1:0]  word_length_select_i,
  input  wire [1:0]  ready_source_select_i,
  input  wire        ready_open_drain_select_i,
  input  wire        ready_pulse_format_i,
  input  wire        timeout_enable_i,
  input  wire        global_chop_i,
  input  wire        current_detect_i,
  input  wire [2:0]  oversampling_ratio_i,
  input  wire [9:0]  channel_phase_setting_i,
  input  wire        first_after_sync_i,
  // converter side
  input  wire [3:0]  chan_done_i,
  input  wire        lag_done_i,
  input  wire        lead_done_i,
  input  wire        detect_i,
  input  wire [95:0] conv_data_i,
  output wire        conv_ready_o,
  // command and answer side
  output reg  [15:0] cmd_o,
  output reg         cmd_valid_o,
  output reg  [15:0] wdata_o,
  output reg         wdata_valid_o,
  input  wire [15:0] response_i,
  input  wire [15:0] status_i,
  input  wire [15:0] read_word_i,
  input  wire [15:0] crc_i,
  output reg  [7:0]  extra_words_o
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg  [1:0] sclk_s_reg;
  reg  [1:0] cs_s_reg;
  reg  [1:0] din_s_reg;
  reg        sclk_d_reg;
  reg        cs_d_reg;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_rise;
  wire       sel;

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sclk_s_reg <= 2'h0;
      cs_s_reg   <= 2'h3;
      din_s_reg  <= 2'h0;
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sclk_s_reg <= {sclk_s_reg[0], sclk_i};
      cs_s_reg   <= {cs_s_reg[0], cs_n_i};
      din_s_reg  <= {din_s_reg[0], din_i};
      sclk_d_reg <= sclk_s_reg[1];
      cs_d_reg   <= cs_s_reg[1];
    end
  end

  assign sel       = ~cs_s_reg[1];
  // clock activity counts only while selected
  assign sclk_rise = sel & sclk_s_reg[1] & ~sclk_d_reg;
  assign sclk_fall = sel & ~sclk_s_reg[1] & sclk_d_reg;
  assign cs_rise   = cs_s_reg[1] & ~cs_d_reg;

  // ---------------------------------------------------------------
  // word length helpers
  // ---------------------------------------------------------------
  function [5:0] wbits;
    input [1:0] wl;
    begin
      case (wl)
        `ADCSP_WL_16: wbits = 6'd16;
        `ADCSP_WL_24: wbits = 6'd24;
        default:      wbits = 6'd32;
      endcase
    end
  endfunction

  // 16-bit words msb-aligned in a 32-bit shift frame
  function [31:0] cword;
    input [15:0] w;
    begin
      cword = {w, 16'h0000};
    end
  endfunction

  function [31:0] dword;
    input [1:0]  wl;
    input [23:0] d;
    begin
      case (wl)
        `ADCSP_WL_16:  dword = {d[23:8], 16'h0000};
        `ADCSP_WL_24:  dword = {d, 8'h00};
        `ADCSP_WL_32Z: dword = {d, 8'h00};
        default:       dword = {{8{d[23]}}, d};
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // conversion fifo
  // ---------------------------------------------------------------
  wire        new_set;
  wire        fifo_out_valid;
  wire [95:0] fifo_data;
  reg         pop_reg;
  reg  [95:0] frame_data_reg;

  adcsp_fifo #(
    .WIDTH       (96),
    .DEPTH       (FIFO_DEPTH),
    .AW          (3)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (new_set),
    .in_ready_o  (conv_ready_o),
    .in_data_i   (conv_data_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop_reg),
    .out_data_o  (fifo_data),
    .count_o     ()
  );

  // ---------------------------------------------------------------
  // ready source and first-ready boundary
  // ---------------------------------------------------------------
  reg  [9:0] bnd;
  reg        has_bnd;
  reg        src_evt;
  reg        hold_first_reg;
  wire       late_first;

  always @* begin
    has_bnd = 1'b1;
    case (oversampling_ratio_i)
      `ADCSP_OSR_64:   bnd = `ADCSP_BND_64;
      `ADCSP_OSR_128:  bnd = `ADCSP_BND_128;
      `ADCSP_OSR_256:  bnd = `ADCSP_BND_256;
      `ADCSP_OSR_512:  bnd = `ADCSP_BND_512;
      `ADCSP_OSR_1024: bnd = `ADCSP_BND_1024;
      default: begin
        bnd     = 10'h000;
        has_bnd = 1'b0;
      end
    endcase
    if (global_chop_i) begin
      src_evt = lag_done_i;
    end else begin
      case (ready_source_select_i)
        `ADCSP_SRC_LAG: src_evt = lag_done_i;
        `ADCSP_SRC_ANY: src_evt = |chan_done_i;
        default:        src_evt = lead_done_i;
      endcase
    end
  end

  // phase at or below the boundary: first result lands a period late
  assign late_first = has_bnd & ~($signed(channel_phase_setting_i) > $signed(bnd));

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hold_first_reg <= 1'b0;
    end else if (first_after_sync_i) begin
      hold_first_reg <= late_first & ~global_chop_i;
    end else if (src_evt) begin
      hold_first_reg <= 1'b0;
    end
  end

  assign new_set = src_evt & ~hold_first_reg & ~current_detect_i;

  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  reg  [31:0] rx_reg;
  reg  [31:0] tx_reg;
  reg  [5:0]  bit_reg;
  reg  [7:0]  word_reg;
  reg  [7:0]  last_reg;
  reg         out_reg;
  reg         rd_op_reg;
  reg  [7:0]  rd_len_reg;
  reg         wr_op_reg;
  reg         done_reg;
  reg  [15:0] to_cnt_reg;
  reg         to_run_reg;
  wire [31:0] rx_next;
  wire        word_end;
  wire        to_hit;
  wire [15:0] rx_word;
  wire [15:0] ans_word;
  wire [7:0]  dat_first;
  wire [7:0]  tx_idx;
  reg  [31:0] tx_word;

  assign rx_next   = {rx_reg[30:0], din_s_reg[1]};
  assign word_end  = sclk_fall & (bit_reg == wbits(word_length_select_i) - 6'd1);
  assign rx_word   = rx_next[wbits(word_length_select_i)-1 -: 16];
  assign ans_word  = (cmd_o == 16'h0000) ? status_i : response_i;
  assign dat_first = rd_op_reg ? rd_len_reg + 8'h01 : 8'h01;
  assign tx_idx    = word_reg;
  assign to_hit    = timeout_enable_i & to_run_reg & (to_cnt_reg == TIMEOUT_CYC - 1);

  // word to load for the next slot in the frame
  always @* begin
    if (rd_op_reg && tx_idx <= rd_len_reg) begin
      tx_word = cword(read_word_i);
    end else if (tx_idx >= dat_first && tx_idx < dat_first + `ADCSP_NCH) begin
      case (tx_idx - dat_first)
        8'h00:   tx_word = dword(word_length_select_i, frame_data_reg[95:72]);
        8'h01:   tx_word = dword(word_length_select_i, frame_data_reg[71:48]);
        8'h02:   tx_word = dword(word_length_select_i, frame_data_reg[47:24]);
        default: tx_word = dword(word_length_select_i, frame_data_reg[23:0]);
      endcase
    end else begin
      tx_word = cword(crc_i);
    end
  end

  always @(posedge sys_clk_i) begin
    pop_reg       <= 1'b0;
    cmd_valid_o   <= 1'b0;
    wdata_valid_o <= 1'b0;
    done_reg      <= 1'b0;
    if (!rst_n_i || cs_rise || to_hit) begin
      rx_reg         <= 32'h0000_0000;
      tx_reg         <= 32'h0000_0000;
      bit_reg        <= 6'd0;
      word_reg       <= 8'h00;
      last_reg       <= 8'h05;
      // armed read count moves into the frame that starts now
      rd_op_reg      <= rst_n_i & (|extra_words_o);
      rd_len_reg     <= rst_n_i ? extra_words_o : 8'h00;
      extra_words_o  <= 8'h00;
      wr_op_reg      <= 1'b0;
      to_cnt_reg     <= 16'h0000;
      to_run_reg     <= 1'b0;
      if (!rst_n_i) begin
        // a cut frame leaves the output bit alone: no glitch on a selected pin
        out_reg        <= 1'b0;
        cmd_o          <= 16'h0000;
        wdata_o        <= 16'h0000;
        frame_data_reg <= 96'h0;
      end
    end else begin
      if (sclk_rise || sclk_fall) begin
        to_cnt_reg <= 16'h0000;
        to_run_reg <= 1'b1;
      end else if (to_run_reg && !to_hit) begin
        to_cnt_reg <= to_cnt_reg + 16'h0001;
      end
      if (sclk_rise) begin
        if (bit_reg == 6'd0 && word_reg == 8'h00) begin
          // first word: answer to previous frame's command
          tx_reg  <= cword(ans_word) << 1;
          out_reg <= ans_word[15];
          if (fifo_out_valid) begin
            frame_data_reg <= fifo_data;
            pop_reg        <= 1'b1;
          end
        end else if (bit_reg == 6'd0) begin
          tx_reg  <= tx_word << 1;
          out_reg <= tx_word[31];
        end else begin
          out_reg <= tx_reg[31];
          tx_reg  <= {tx_reg[30:0], 1'b0};
        end
      end
      if (sclk_fall) begin
        rx_reg  <= rx_next;
        bit_reg <= bit_reg + 6'd1;
      end
      if (word_end) begin
        bit_reg  <= 6'd0;
        word_reg <= word_reg + 8'h01;
        if (word_reg == 8'h00) begin
          cmd_o       <= rx_word;
          cmd_valid_o <= 1'b1;
          if (rx_word[15:13] == `ADCSP_CMD_WRITE) begin
            wr_op_reg <= 1'b1;
            last_reg  <= 8'h05 + {1'b0, rx_word[6:0]};
          end
        end else if (wr_op_reg && word_reg <= last_reg - 8'h04) begin
          wdata_o       <= rx_word;
          wdata_valid_o <= 1'b1;
        end
        if (word_reg == dat_first + `ADCSP_NCH - 8'h01) begin
          done_reg <= 1'b1;
        end
      end
      if (cmd_valid_o && cmd_o[15:13] == `ADCSP_CMD_READ && |cmd_o[6:0]) begin
        // multi-read armed: response words lengthen the following frame
        extra_words_o <= {1'b0, cmd_o[6:0]} + 8'h01;
      end
    end
  end

  // serial output floats whenever deselected
  assign dout_o    = out_reg;
  assign dout_oe_o = sel;

  // ---------------------------------------------------------------
  // ready pin
  // ---------------------------------------------------------------
  wire reading;
  assign reading = sel & (word_reg != 8'h00) & (word_reg < dat_first + `ADCSP_NCH);

  adcsp_ready u_ready (
    .sys_clk_i                 (sys_clk_i),
    .rst_n_i                   (rst_n_i),
    .ready_pulse_format_i      (ready_pulse_format_i),
    .ready_open_drain_select_i (ready_open_drain_select_i),
    .new_data_i                (new_set | (current_detect_i & detect_i)),
    .reading_i                 (reading),
    .data_done_i               (done_reg),
    .data_ready_n_o            (data_ready_n_o),
    .data_ready_n_oe_o         (data_ready_n_oe_o)
  );
endmodule

// ---- adcsp_defs.vh ----
// adcsp_defs.vh - constants for the converter serial peripheral port
// assumes: included by adcsp_core and adcsp_ready; the fifo does not include it
`ifndef ADCSP_DEFS_VH
`define ADCSP_DEFS_VH

// word length select encodings
`define ADCSP_WL_16        2'h0
`define ADCSP_WL_24        2'h1
`define ADCSP_WL_32Z       2'h2
`define ADCSP_WL_32S       2'h3
`define ADCSP_WL_RESET     2'h1

// ready source select encodings
`define ADCSP_SRC_LAG      2'h0
`define ADCSP_SRC_ANY      2'h1

// oversampling ratio codes
`define ADCSP_OSR_64       3'h0
`define ADCSP_OSR_128      3'h1
`define ADCSP_OSR_256      3'h2
`define ADCSP_OSR_512      3'h3
`define ADCSP_OSR_1024     3'h4

// first-ready phase boundaries (10-bit two's complement)
`define ADCSP_BND_64       10'h00D
`define ADCSP_BND_128      10'h3ED
`define ADCSP_BND_256      10'h3AD
`define ADCSP_BND_512      10'h32D
`define ADCSP_BND_1024     10'h22D

// frame layout
`define ADCSP_NCH          4
`define ADCSP_FRAME_WORDS  6
`define ADCSP_CMD_WRITE    3'h3
`define ADCSP_CMD_READ     3'h5

// timeout: 2^15 master clock cycles
`define ADCSP_TIMEOUT_CYC  32768

// ready pulse width in system cycles
`define ADCSP_PULSE_CYC    3'h4

`endif

// ---- adcsp_fifo.v ----
// adcsp_fifo.v - small synchronous fifo for conversion data sets
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
module adcsp_fifo #(
  parameter WIDTH = 96,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_n_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // level
  output wire [AW:0]      count_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_reg;
  reg [AW-1:0]    rd_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_reg];
  assign count_o     = cnt_reg;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
    if (!rst_n_i) begin
      wr_reg  <= {AW{1'b0}};
      rd_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ---- adcsp_ready.v ----
// adcsp_ready.v - data-ready pin generator
// assumes: events arrive as one-cycle pulses on sys_clk_i
`timescale 1ns/1ps
`include "adcsp_defs.vh"
module adcsp_ready (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  // configuration
  input  wire       ready_pulse_format_i,
  input  wire       ready_open_drain_select_i,
  // events
  input  wire       new_data_i,
  input  wire       reading_i,
  input  wire       data_done_i,
  // pin
  output wire       data_ready_n_o,
  output wire       data_ready_n_oe_o
);
  reg       low_reg;
  reg       skip_reg;
  reg [2:0] pw_reg;
  reg       unread_reg;

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      low_reg    <= 1'b0;
      skip_reg   <= 1'b0;
      pw_reg     <= 3'h0;
      unread_reg <= 1'b0;
    end else if (ready_pulse_format_i) begin
      // pulse form: one short low pulse per set, none for a set that is skipped while one is unread
      if (pw_reg != 3'h0) begin
        pw_reg <= pw_reg - 3'h1;
      end
      low_reg <= (pw_reg > 3'h1);
      if (data_done_i) begin
        unread_reg <= 1'b0;
      end
      if (new_data_i && !reading_i) begin
        if (unread_reg && !skip_reg) begin
          skip_reg <= 1'b1;
        end else begin
          skip_reg   <= 1'b0;
          unread_reg <= 1'b1;
          pw_reg     <= `ADCSP_PULSE_CYC;
          low_reg    <= 1'b1;
        end
      end
    end else begin
      // level form: low until the last data word leaves
      pw_reg     <= 3'h0;
      skip_reg   <= 1'b0;
      unread_reg <= 1'b0;
      if (new_data_i && !reading_i) begin
        low_reg <= 1'b1;
      end else if (data_done_i) begin
        low_reg <= 1'b0;
      end
    end
  end

  assign data_ready_n_o    = ~low_reg;
  assign data_ready_n_oe_o = low_reg | ~ready_open_drain_select_i;
endmodule

// ---- adcsp_checker.sv ----
// adcsp_checker.sv - port assertions for the converter serial port
// assumes: bound to adcsp_core; link pins are slow next to sys_clk_i
`timescale 1ns/1ps
module adcsp_checker #(
  parameter TIMEOUT_CYC = 64,
  parameter FIFO_DEPTH  = 8
) (
  // clock and reset
  input wire       sys_clk_i,
  input wire       rst_n_i,
  // serial pins and command strobe
  input wire       sclk_i,
  input wire       cs_n_i,
  input wire       dout_o,
  input wire       dout_oe_o,
  input wire       cmd_valid_o,
  // ready pin and its configuration
  input wire       data_ready_n_o,
  input wire       data_ready_n_oe_o,
  input wire [1:0] ready_source_select_i,
  input wire       ready_open_drain_select_i,
  input wire       ready_pulse_format_i,
  input wire       global_chop_i,
  input wire       current_detect_i,
  // converter events
  input wire [3:0] chan_done_i,
  input wire       detect_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // named steps of a ready pulse
  // ----------------------------------------
  sequence s_pulse_start;
    ready_pulse_format_i && $fell(data_ready_n_o);
  endsequence
  sequence s_pulse_body;
    (!data_ready_n_o) [*4] ##1 data_ready_n_o;
  endsequence
  AST_DESEL_FLOAT: assert property (cs_n_i [*4] |-> !dout_oe_o)
    else $error("serial output driven while deselected");
  AST_SEL_DRIVE: assert property ((!cs_n_i) [*4] |-> dout_oe_o)
    else $error("serial output floating while selected");
  AST_DESEL_IGNORE: assert property (cs_n_i [*6] |-> !cmd_valid_o)
    else $error("command taken while deselected");
  // sync delay puts every legal change a few cycles into the high half
  AST_DOUT_ON_RISE: assert property ($changed(dout_o) && dout_oe_o && $past(dout_oe_o)
    |-> $past(sclk_i, 2)) else $error("serial output moved outside a rising edge");
  AST_OD_FLOAT: assert property (ready_open_drain_select_i &&
    $stable(ready_open_drain_select_i) && data_ready_n_o |-> !data_ready_n_oe_o)
    else $error("open-drain ready driven high");
  AST_PP_DRIVE: assert property (!ready_open_drain_select_i &&
    $stable(ready_open_drain_select_i) |-> data_ready_n_oe_o)
    else $error("push-pull ready not driven");
  AST_LOW_DRIVEN: assert property (!data_ready_n_o |-> data_ready_n_oe_o)
    else $error("asserted ready not driven");
  AST_PULSE_WIDTH: assert property (s_pulse_start |-> s_pulse_body)
    else $error("ready pulse has wrong width");
  AST_ANY_READY: assert property (!ready_pulse_format_i && !global_chop_i &&
    !current_detect_i && ready_source_select_i == 2'h1 && (|chan_done_i) && cs_n_i
    |-> ##[1:8] !data_ready_n_o) else $error("ready missing after channel data");
  AST_DETECT_READY: assert property (current_detect_i && detect_i &&
    !ready_pulse_format_i && cs_n_i |-> ##[1:8] !data_ready_n_o)
    else $error("ready missing after detection");
endmodule
bind adcsp_core adcsp_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .FIFO_DEPTH(FIFO_DEPTH))
  adcsp_checker_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .cmd_valid_o(cmd_valid_o),
  .data_ready_n_o(data_ready_n_o), .data_ready_n_oe_o(data_ready_n_oe_o),
  .ready_source_select_i(ready_source_select_i), .global_chop_i(global_chop_i),
  .ready_open_drain_select_i(ready_open_drain_select_i), .detect_i(detect_i),
  .ready_pulse_format_i(ready_pulse_format_i), .current_detect_i(current_detect_i),
  .chan_done_i(chan_done_i));

// ---- adcsp_host.sv ----
// adcsp_host.sv - host controller model on the serial link
// assumes: the bench calls select and shift; 800 ns link clock period
`timescale 1ns/1ps
module adcsp_host (
  // link pins
  output reg  sclk_o,
  output reg  cs_n_o,
  output reg  din_o,
  input  wire dout_i
);
  initial begin
    sclk_o = 1'b0; // clock rests low
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // released data line wanders so a stale level is never trusted
  always #400 if (cs_n_o) din_o = ~din_o;
  task select(input b);
    begin
      cs_n_o = b; // held by the caller across a whole frame
      #400;
    end
  endtask
  task shift(input [31:0] w, input integer n, output [31:0] r);
    integer i;
    begin
      r = 32'h0000_0000;
      for (i = n - 1; i >= 0; i = i - 1) begin
        sclk_o = 1'b1;
        din_o  = w[i]; // launched on rise only
        #400;
        sclk_o = 1'b0;
        // device sees pins through a sync chain, so sample late in the low half
        #300;
        r[i] = dout_i;
        #100;
      end
    end
  endtask
endmodule

// ---- tb_top.sv ----
// tb_top.sv - self-checking bench for the converter serial port
// assumes: adcsp_core, adcsp_host and the bound checker compiled alongside
`timescale 1ns/1ps
module tb_top;
  localparam TIMEOUT_CYC = 64;
  reg         sys_clk_i = 1'b0;
  reg         rst_n_i   = 1'b0;
  reg  [1:0]  wl = 2'h1, src = 2'h1;
  reg         od = 1'b0, fmt = 1'b0, to_en = 1'b1, gc = 1'b0, cd = 1'b0, syn = 1'b0;
  reg         lag = 1'b0, lead = 1'b0, det = 1'b0, flt = 1'b0, rdy_d = 1'b1;
  reg  [3:0]  done = 4'h0;
  reg  [15:0] prev_c = 16'h0000;
  reg  [2:0]  oversampling_ratio;
  reg  [9:0]  phase;
  reg  [95:0] conv = 96'h0;
  reg  [15:0] resp = 16'h0000, stat = 16'h0000, rword = 16'h0000, crc = 16'h0000;
  reg  [31:0] rng = 32'hec6f_6625;
  wire        sclk, cs_n, din, dout, dout_oe, rdy_n, rdy_oe, conv_rdy, cmd_v, wd_v;
  wire [15:0] cmd, wd;
  wire [7:0]  extra;
  wire        dout_w  = dout_oe ? dout : flt;
  wire        rdy_pin = rdy_oe ? rdy_n : 1'b1; // pull-up on the ready line
  integer     err_count = 0;
  integer     n_checks  = 0;
  integer     falls     = 0;
  integer     i, k;
  reg  [95:0] sets [$];
  adcsp_core #(.TIMEOUT_CYC(TIMEOUT_CYC), .FIFO_DEPTH(8)) adcsp_core_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout), .dout_oe_o(dout_oe), .data_ready_n_o(rdy_n), .data_ready_n_oe_o(rdy_oe),
    .word_length_select_i(wl), .ready_source_select_i(src), .ready_open_drain_select_i(od),
    .ready_pulse_format_i(fmt), .timeout_enable_i(to_en), .global_chop_i(gc),
    .current_detect_i(cd), .oversampling_ratio_i(oversampling_ratio), .channel_phase_setting_i(phase),
    .first_after_sync_i(syn), .chan_done_i(done), .lag_done_i(lag), .lead_done_i(lead),
    .detect_i(det), .conv_data_i(conv), .conv_ready_o(conv_rdy), .cmd_o(cmd),
    .cmd_valid_o(cmd_v), .wdata_o(wd), .wdata_valid_o(wd_v), .response_i(resp),
    .status_i(stat), .read_word_i(rword), .crc_i(crc), .extra_words_o(extra));
  adcsp_host adcsp_host_inst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_w));
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    flt   <= ~flt;
    rdy_d <= rdy_pin;
    if (rdy_d === 1'b1 && rdy_pin === 1'b0) falls <= falls + 1;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] xs();
    begin
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      xs  = rng;
    end
  endfunction
  function [31:0] al16(input [15:0] w, input [1:0] l);
    al16 = (l == 2'h0) ? {16'h0000, w} : (l == 2'h1) ? {8'h00, w, 8'h00} : {w, 16'h0000};
  endfunction
  function [31:0] al24(input [23:0] d, input [1:0] l);
    case (l)
      2'h0:    al24 = {16'h0000, d[23:8]};
      2'h1:    al24 = {8'h00, d};
      2'h2:    al24 = {d, 8'h00};
      default: al24 = {{8{d[23]}}, d};
    endcase
  endfunction
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // one converter data set, kept by the model only if the buffer had room
  task push;
    reg [95:0] d;
    begin
      d = {xs(), xs(), xs()};
      @(posedge sys_clk_i);
      #1;
      if (conv_rdy === 1'b1) sets.push_back(d);
      conv = d;
      done = 4'hf;
      lag  = 1'b1;
      lead = 1'b1;
      @(posedge sys_clk_i);
      #1;
      done = 4'h0;
      lag  = 1'b0;
      lead = 1'b0;
      repeat (10) @(posedge sys_clk_i);
      #1;
    end
  endtask
  // junk 1: partial word then deselect; junk 2: partial word then silence
  task frame(input [1:0] l, input integer junk);
    integer    w;
    integer    nb;
    reg [15:0] c;
    reg [31:0] r;
    reg [95:0] s;
    reg        have;
    begin
      @(posedge sys_clk_i);
      #1;
      wl = l;
      r = xs();
      c = {3'h0, r[12:0]}; // ordinary command only
      resp = r[31:16];
      r = xs();
      crc = r[15:0];
      stat = r[31:16];
      rword = r[15:0] ^ r[31:16];
      nb = (l == 2'h0) ? 16 : (l == 2'h1) ? 24 : 32;
      have = (sets.size() > 0);
      if (have) s = sets.pop_front();
      adcsp_host_inst.select(1'b0);
      if (junk != 0) begin
        adcsp_host_inst.shift(32'h0000_001f, 5, r);
        if (junk == 1) begin
          adcsp_host_inst.select(1'b1);
          adcsp_host_inst.select(1'b0);
        end else
          #(TIMEOUT_CYC * 150);
      end
      for (w = 0; w < 6; w = w + 1) begin
        adcsp_host_inst.shift((w == 0) ? al16(c, l) : 32'h0000_0000, nb, r);
        if (w == 0)
          check("response word", r, al16((prev_c == 16'h0000) ? stat : resp, l));
        else if (w == 5)
          check("check word", r, al16(crc, l));
        else if (have)
          check("channel word", r, al24(s[119 - 24 * w -: 24], l));
      end
      adcsp_host_inst.select(1'b1);
      check("command", {16'h0000, cmd}, {16'h0000, c});
      prev_c = c;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rng = xs();
    oversampling_ratio = rng[2:0];
    phase = rng[12:3];
    repeat (8) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    for (i = 0; i < 4; i = i + 1) begin
      push;
      check("ready asserted", {31'h0, rdy_pin}, 32'h0);
      frame(i[1:0], 0);
      check("ready released", {31'h0, rdy_pin}, 32'h1);
    end
    $display("test word lengths done");
    for (i = 1; i < 3; i = i + 1) begin
      push;
      frame(2'h1, i);
    end
    $display("test frame restart done");
    for (i = 0; i < 9; i = i + 1) push;
    check("buffer full", {31'h0, conv_rdy}, 32'h0);
    for (i = 0; i < 8; i = i + 1) frame(2'h1, 0);
    check("buffer empty", {31'h0, conv_rdy}, 32'h1);
    $display("test buffer done");
    src = 2'h0;
    syn = 1'b1;
    @(posedge sys_clk_i);
    #1;
    syn = 1'b0;
    push;
    k = (oversampling_ratio == 3'h0) ? 13 : (oversampling_ratio == 3'h1) ? -19 : (oversampling_ratio == 3'h2) ? -83 : -211;
    if (oversampling_ratio == 3'h4) k = -467;
    check("first ready", {31'h0, rdy_pin}, {31'h0, oversampling_ratio < 3'h5 && $signed(phase) <= k});
    $display("test first ready done");
    @(posedge sys_clk_i);
    #1;
    od = 1'b1;
    fmt = 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      k = falls;
      push;
      check("ready pulses", falls - k, (i == 1) ? 0 : 1);
    end
    $display("test pulse form done");
    od = 1'b0;
    fmt = 1'b0;
    cd = 1'b1;
    @(posedge sys_clk_i);
    #1;
    det = 1'b1;
    @(posedge sys_clk_i);
    #1;
    det = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    check("detect ready", {31'h0, rdy_pin}, 32'h0);
    $display("test current detect done");
    stop_test;
  end
endmodule
